// *** rtl/ewic_ctrl.sv ***
// wait-state and idle-cycle timing control for external areas 0 to 6
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps

// Overview of operation
// [RL1] area idle field sets idle cycles, areas 0-6
// [RL2] single-address dma slot uses dma_acknowledge_device idle field
// [RL3] dma_acknowledge_device idle inserted on device switch
// [RL4] mpx marked slots get one idle minimum; code never forces it after a cpu write or a dma write to the same area
// [RL5] software zeroes dma_acknowledge_device/area3 idle in ras-down
// [RL6] idle after mpx write to same area
// [RL7] ras-down/dma case: idle if pipeline busy
// [RL8] zero idle setting inserts no idle
// [RL9] idle fields reset to fifteen cycles
// [RL10] wait register resets FFFEEFFF, power-on only
// [RL11] wait register field layout per area
// [RL12] wait register reserved bits read zero
// [RL13] first wait codes map to 0..15 waits
// [RL14] burst rom pitch waits equal code
// [RL15] ready pin honoured only nonzero, sram/mpx
// [RL16] idle codes map to 0..15 cycles
// [RL17] area idle on area switch or read-to-write
// [RL18] dual-address dma treated like cpu access
// [RL19] count on bus clock, strobes held meanwhile
module ewic_ctrl
    import ewic_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    input wire logic reqValid,
    input wire ewic_acc_t reqAcc,
    output logic reqReady,
    input wire logic sdramPipeBusy,
    input wire logic dmaSdram,
    input wire logic rdyN,
    output logic idleActive,
    output logic strobeHold,
    output logic accessDone
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // 3-bit code to 0,1,2,3,6,9,12,15
    function automatic logic [3:0] dec_code(input logic [2:0] c);
        logic [3:0] r;
        r = 4'h0;
        unique case (c)
            3'd0: r = 4'h0;
            3'd1: r = 4'h1;
            3'd2: r = 4'h2;
            3'd3: r = 4'h3;
            3'd4: r = 4'h6;
            3'd5: r = 4'h9;
            3'd6: r = 4'hC;
            3'd7: r = 4'hF;
        endcase
        return r;
    endfunction

    function automatic logic [2:0] field3(input logic [31:0] r, input logic [4:0] lsb);
        logic [31:0] s;
        s = r >> lsb;
        return s[2:0];
    endfunction

    function automatic ewic_if_t if_of(input logic [31:0] cfg, input logic [2:0] a);
        logic [31:0] s;
        s = cfg >> {a, 1'b0};
        return ewic_if_t'(s[1:0]);
    endfunction

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_GAP, ST_ACC} ewic_st_t;

    logic [31:0] idleReg_q;
    logic [31:0] waitReg_q;
    logic [31:0] cfgReg_q;
    logic [31:0] rdData_q;
    ewic_st_t state_q;
    logic [3:0] cnt_q;
    logic [3:0] waitLoad_q;
    logic honour_q;
    logic done_q;
    ewic_acc_t prev_q;
    logic prevValid_q;
    logic rdyMeta_q;
    logic rdySync_q;

    // software registers; only the asynchronous (power-on) reset loads their reset values
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            idleReg_q <= EWIC_IDLE_RST; // [RL9]
            waitReg_q <= EWIC_WAIT_RST; // [RL10]
            cfgReg_q <= EWIC_CFG_RST;
        end else if (clkEn && regWr) begin
            if (regAddr == EWIC_IDLE_OFS) begin
                idleReg_q <= regWrData & EWIC_IDLE_MASK;
            end
            if (regAddr == EWIC_WAIT_OFS) begin
                waitReg_q <= regWrData & EWIC_WAIT_MASK; // [RL11] [RL12]
            end
            if (regAddr == EWIC_CFG_OFS) begin
                cfgReg_q <= regWrData & EWIC_CFG_MASK;
            end
        end
    end

    // ----------------------------------------------------------------
    // read port, data valid the cycle after the strobe only
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdData_q <= 32'h0000_0000;
        end else if (clkEn) begin
            rdData_q <= 32'h0000_0000;
            if (regRd) begin
                unique case (regAddr)
                    EWIC_IDLE_OFS: rdData_q <= idleReg_q;
                    EWIC_WAIT_OFS: rdData_q <= waitReg_q; // [RL12]
                    EWIC_CFG_OFS: rdData_q <= cfgReg_q;
                    EWIC_STAT_OFS: rdData_q <= {20'h0_0000, prevValid_q, prev_q.area,
                        cnt_q, 2'b00, state_q};
                    default: rdData_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign regRdData = rdData_q;

    // ----------------------------------------------------------------
    // ready pin synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdyMeta_q <= 1'b1;
            rdySync_q <= 1'b1;
        end else if (clkEn) begin
            rdyMeta_q <= rdyN;
            rdySync_q <= rdyMeta_q;
        end
    end

    // ----------------------------------------------------------------
    // idle and wait decision for the request on offer
    // ----------------------------------------------------------------
    ewic_if_t curIf;
    logic [3:0] idleNeed;
    logic [3:0] waitNeed;
    logic honourNeed;
    logic [3:0] areaIdle;
    logic [3:0] dackIdle;
    logic [2:0] waitCode;
    logic [2:0] pitchCode;
    logic hasPitch;
    logic sameArea;
    logic curMpx;
    logic rasDown;

    always_comb begin
        curIf = if_of(cfgReg_q, reqAcc.area);
        curMpx = (curIf == EWIC_IF_MPX);
        rasDown = cfgReg_q[EWIC_RAS_DOWN_BIT];
        sameArea = (reqAcc.area == prev_q.area);
        areaIdle = dec_code(field3(idleReg_q, {prev_q.area, 2'b00})); // [RL1] [RL16]
        dackIdle = dec_code(field3(idleReg_q, EWIC_DMA_ACKNOWLEDGE_DEVICE_IDLE_LSB)); // [RL2] [RL16]
        idleNeed = 4'h0;
        if (prevValid_q) begin
            if (prev_q.isDma && prev_q.isWrite) begin
                idleNeed = dackIdle; // [RL2]
                if (curMpx && !sameArea && idleNeed == 4'h0) begin
                    idleNeed = 4'(EWIC_MPX_MIN_IDLE); // [RL4]
                end
            end else if (prev_q.isDma && reqAcc.isDma && prev_q.dackId != reqAcc.dackId) begin
                idleNeed = dackIdle; // [RL3]
            end else if (!sameArea) begin
                idleNeed = areaIdle; // [RL17] [RL18]
                // a switch to a new area after a plain write carries no forced minimum
                if (curMpx && !prev_q.isWrite && idleNeed == 4'h0) begin
                    idleNeed = 4'(EWIC_MPX_MIN_IDLE); // [RL4]
                end
            end else if (!prev_q.isWrite) begin
                if (reqAcc.isWrite) begin
                    idleNeed = areaIdle; // [RL17]
                end
                if (curMpx && !prev_q.isDma && idleNeed == 4'h0) begin
                    idleNeed = 4'(EWIC_MPX_MIN_IDLE); // [RL4]
                end
            end else if (if_of(cfgReg_q, prev_q.area) == EWIC_IF_MPX) begin
                // ras-down/dma exemption lapses while the sdram pipeline is busy
                if (!(rasDown || dmaSdram) || sdramPipeBusy) begin
                    idleNeed = areaIdle; // [RL6] [RL7] [RL8]
                end
            end
        end
        waitCode = field3(waitReg_q, ewic_wait_lsb(reqAcc.area));
        hasPitch = 1'b0;
        pitchCode = 3'd0;
        unique case (reqAcc.area)
            3'd0: begin
                hasPitch = 1'b1;
                pitchCode = field3(waitReg_q, EWIC_A0_PITCH_LSB);
            end
            3'd5: begin
                hasPitch = 1'b1;
                pitchCode = field3(waitReg_q, EWIC_A5_PITCH_LSB);
            end
            3'd6: begin
                hasPitch = 1'b1;
                pitchCode = field3(waitReg_q, EWIC_A6_PITCH_LSB);
            end
            default: begin
                hasPitch = 1'b0;
                pitchCode = 3'd0;
            end
        endcase
        if (curIf == EWIC_IF_DRAM) begin
            // cas timing belongs to the dram sequencer, not to this counter
            waitNeed = 4'h0;
            honourNeed = 1'b0; // [RL15]
        end else if (curIf == EWIC_IF_BROM && reqAcc.burstNext && hasPitch) begin
            waitNeed = {1'b0, pitchCode}; // [RL14]
            honourNeed = 1'b0; // [RL15]
        end else begin
            waitNeed = dec_code(waitCode); // [RL13]
            honourNeed = (waitCode != 3'd0) && (curIf != EWIC_IF_BROM); // [RL15]
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            waitLoad_q <= 4'h0;
            honour_q <= 1'b0;
            done_q <= 1'b0;
        end else if (clkEn) begin
            done_q <= 1'b0;
            unique case (state_q)
                ST_IDLE: begin
                    if (reqValid) begin
                        waitLoad_q <= waitNeed;
                        honour_q <= honourNeed;
                        if (idleNeed != 4'h0) begin
                            state_q <= ST_GAP;
                            cnt_q <= idleNeed - 4'h1;
                        end else begin
                            state_q <= ST_ACC; // [RL8]
                            cnt_q <= waitNeed;
                        end
                    end
                end
                ST_GAP: begin
                    if (cnt_q != 4'h0) begin
                        cnt_q <= cnt_q - 4'h1; // [RL19]
                    end else begin
                        state_q <= ST_ACC;
                        cnt_q <= waitLoad_q;
                    end
                end
                ST_ACC: begin
                    if (cnt_q != 4'h0) begin
                        cnt_q <= cnt_q - 4'h1; // [RL19]
                    end else if (!honour_q || !rdySync_q) begin
                        state_q <= ST_IDLE; // [RL15]
                        done_q <= 1'b1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // history of the last accepted access
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_q <= '0;
            prevValid_q <= 1'b0;
        end else if (clkEn && state_q == ST_IDLE && reqValid) begin
            prev_q <= reqAcc;
            prevValid_q <= 1'b1;
        end
    end

    assign reqReady = (state_q == ST_IDLE);
    assign idleActive = (state_q == ST_GAP);
    assign strobeHold = (state_q == ST_ACC); // [RL19]
    assign accessDone = done_q;

endmodule

// *** pkg/ewic_pkg.sv ***
// constants, field layouts and carriers for the external area wait/idle controller
package ewic_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] EWIC_IDLE_OFS = 8'h00;
    localparam logic [7:0] EWIC_WAIT_OFS = 8'h04;
    localparam logic [7:0] EWIC_CFG_OFS = 8'h08;
    localparam logic [7:0] EWIC_STAT_OFS = 8'h0C;

    // ----------------------------------------------------------------
    // reset values and writable masks
    // ----------------------------------------------------------------
    localparam logic [31:0] EWIC_IDLE_RST = 32'h7777_7777;
    localparam logic [31:0] EWIC_IDLE_MASK = 32'h7777_7777;
    localparam logic [31:0] EWIC_WAIT_RST = 32'hFFFE_EFFF;
    localparam logic [31:0] EWIC_WAIT_MASK = 32'hFFFE_EFFF;
    localparam logic [31:0] EWIC_CFG_RST = 32'h0000_0000;
    localparam logic [31:0] EWIC_CFG_MASK = 32'h0001_3FFF;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam logic [4:0] EWIC_DMA_ACKNOWLEDGE_DEVICE_IDLE_LSB = 5'd28;
    localparam logic [4:0] EWIC_A6_WAIT_LSB = 5'd29;
    localparam logic [4:0] EWIC_A6_PITCH_LSB = 5'd26;
    localparam logic [4:0] EWIC_A5_WAIT_LSB = 5'd23;
    localparam logic [4:0] EWIC_A5_PITCH_LSB = 5'd20;
    localparam logic [4:0] EWIC_A4_WAIT_LSB = 5'd17;
    localparam logic [4:0] EWIC_A3_WAIT_LSB = 5'd13;
    localparam logic [4:0] EWIC_A2_WAIT_LSB = 5'd9;
    localparam logic [4:0] EWIC_A1_WAIT_LSB = 5'd6;
    localparam logic [4:0] EWIC_A0_WAIT_LSB = 5'd3;
    localparam logic [4:0] EWIC_A0_PITCH_LSB = 5'd0;
    localparam int EWIC_RAS_DOWN_BIT = 16;
    localparam int EWIC_MPX_MIN_IDLE = 1;

    // ----------------------------------------------------------------
    // memory interface kind per area, two bits each in the config register
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        EWIC_IF_SRAM = 2'h0,
        EWIC_IF_BROM = 2'h1,
        EWIC_IF_MPX = 2'h2,
        EWIC_IF_DRAM = 2'h3
    } ewic_if_t;

    // ----------------------------------------------------------------
    // access carrier
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] area;
        logic isWrite;
        logic isDma;
        logic [1:0] dackId;
        logic burstNext;
    } ewic_acc_t;

    function automatic logic [4:0] ewic_wait_lsb(input logic [2:0] a);
        logic [4:0] r;
        r = EWIC_A0_WAIT_LSB;
        unique case (a)
            3'd0: r = EWIC_A0_WAIT_LSB;
            3'd1: r = EWIC_A1_WAIT_LSB;
            3'd2: r = EWIC_A2_WAIT_LSB;
            3'd3: r = EWIC_A3_WAIT_LSB;
            3'd4: r = EWIC_A4_WAIT_LSB;
            3'd5: r = EWIC_A5_WAIT_LSB;
            default: r = EWIC_A6_WAIT_LSB;
        endcase
        return r;
    endfunction

endpackage

// *** verif/ewic_ctrl_monitor.sv ***
// port-level assertions for the wait/idle controller
`timescale 1ns/10ps
module ewic_ctrl_monitor
    import ewic_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdData,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire logic idleActive,
    input wire logic strobeHold,
    input wire logic accessDone
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic [7:0] idleRun_q;
    logic idleZero_q;
    logic noMpx_q;
    function automatic logic hasMpx(input logic [13:0] c);
        logic r;
        r = 1'b0;
        for (int n = 0; n < 7; n++) begin
            r |= c[2*n +: 2] == 2'h2;
        end
        return r;
    endfunction
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            idleRun_q <= 8'h00;
        end else begin
            idleRun_q <= idleActive ? idleRun_q + 8'h01 : 8'h00;
        end
    end
    // shadows of what software wrote, for the zero-idle case
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            idleZero_q <= 1'b0;
            noMpx_q <= 1'b1;
        end else if (regWr && regAddr == EWIC_IDLE_OFS) begin
            idleZero_q <= (regWrData & EWIC_IDLE_MASK) == 32'h0000_0000;
        end else if (regWr && regAddr == EWIC_CFG_OFS) begin
            noMpx_q <= !hasMpx(regWrData[13:0]);
        end
    end
    sequence takeS;
        reqValid && reqReady;
    endsequence
    sequence busyS;
        idleActive || strobeHold;
    endsequence
    take_starts_a: assert property (takeS |=> busyS)
        else $error("access did not start after take");
    busy_not_ready_a: assert property (busyS |-> !reqReady)
        else $error("ready while busy");
    phase_excl_a: assert property (!(idleActive && strobeHold))
        else $error("idle and strobe together");
    idle_to_strobe_a: assert property ($fell(idleActive) |-> strobeHold)
        else $error("idle not followed by access");
    done_after_a: assert property (accessDone |-> $past(strobeHold) && !busyS)
        else $error("done without access cycle");
    done_pulse_a: assert property (accessDone |=> !accessDone)
        else $error("done longer than one cycle");
    idle_run_a: assert property (idleRun_q <= 8'h0F)
        else $error("idle run above fifteen");
    idle_zero_a: assert property (takeS and idleZero_q && noMpx_q |=> !idleActive)
        else $error("idle inserted with zero setting");
    reserved_bits_a: assert property ($past(regRd) && $past(regAddr) == EWIC_WAIT_OFS
        |-> regRdData[16] == 1'b0 && regRdData[12] == 1'b0)
        else $error("reserved wait bits not zero");
    rdata_pulse_a: assert property (!$past(regRd) |-> regRdData == 32'h0000_0000)
        else $error("read data outside its cycle");
endmodule

// *** verif/ewic_mem_model.sv ***
// far-side memory model that drives the ready pin
`timescale 1ns/10ps
module ewic_mem_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic strobeHold,
    input wire logic [3:0] rdyDelay,
    output logic rdyN
);
    logic [3:0] cnt_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= !strobeHold ? 4'h0 : (cnt_q == 4'hF) ? cnt_q : cnt_q + 4'h1;
        end
    end
    // pulled-up pin: a slow device reads not ready while deselected
    assign rdyN = (rdyDelay == 4'h0) ? 1'b0 : !(strobeHold && cnt_q >= rdyDelay);
endmodule

// *** verif/tb_top.sv ***
// self-checking bench for the wait/idle controller
`timescale 1ns/10ps
module tb_top;
    import ewic_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0000_0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic reqValid = 1'b0;
    ewic_acc_t reqAcc = '0;
    logic sdramPipeBusy = 1'b0;
    logic dmaSdram = 1'b0;
    logic [3:0] rdyDelay = 4'h0;
    logic [31:0] regRdData;
    logic reqReady, idleActive, strobeHold, accessDone, rdyN;
    logic [31:0] lfsr = 32'h0000_002A;
    logic [31:0] idleReg, waitReg, cfgReg;
    ewic_acc_t prevAcc = '0;
    int wl[7] = '{3, 6, 9, 13, 17, 23, 29};
    int num_errors = 0;
    int comparisons = 0;
    always #4 clk = ~clk;
    ewic_ctrl DUT (.clk(clk), .arst_n(arst_n), .clkEn(1'b1), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .reqValid(reqValid), .reqAcc(reqAcc), .reqReady(reqReady),
        .sdramPipeBusy(sdramPipeBusy), .dmaSdram(dmaSdram), .rdyN(rdyN),
        .idleActive(idleActive), .strobeHold(strobeHold), .accessDone(accessDone));
    ewic_mem_model u_mem (.clk(clk), .arst_n(arst_n), .strobeHold(strobeHold),
        .rdyDelay(rdyDelay), .rdyN(rdyN));
    function automatic logic [31:0] nextRand();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    function automatic int dec(input logic [2:0] c);
        int t[8] = '{0, 1, 2, 3, 6, 9, 12, 15};
        return t[c];
    endfunction
    function automatic int expIdle(input ewic_acc_t p, input ewic_acc_t c);
        logic multiplexed_addr_data_interface;
        int ai, dk;
        multiplexed_addr_data_interface = cfgReg[2*c.area +: 2] == EWIC_IF_MPX;
        ai = dec(idleReg[4*p.area +: 3]);
        dk = dec(idleReg[30:28]);
        if (p.isDma && p.isWrite) return (multiplexed_addr_data_interface && c.area != p.area && dk == 0) ? 1 : dk;
        if (p.isDma && c.isDma && c.dackId != p.dackId) return dk;
        if (c.area != p.area) return (multiplexed_addr_data_interface && !p.isWrite && ai == 0) ? 1 : ai;
        if (!p.isWrite && c.isWrite && ai != 0) return ai;
        if (!p.isWrite) return (multiplexed_addr_data_interface && !p.isDma) ? 1 : 0;
        if (multiplexed_addr_data_interface) return ((cfgReg[16] || dmaSdram) && !sdramPipeBusy) ? 0 : ai;
        return 0;
    endfunction
    function automatic int expWait(input ewic_acc_t c);
        logic [1:0] f;
        f = cfgReg[2*c.area +: 2];
        if (f == EWIC_IF_DRAM) return 0;
        if (f == EWIC_IF_BROM && c.burstNext && c.area inside {3'd0, 3'd5, 3'd6})
            return int'(waitReg[((c.area == 3'd0) ? 0 : (c.area == 3'd5) ? 20 : 26) +: 3]);
        return dec(waitReg[wl[c.area] +: 3]);
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic regRead(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        check("read data", exp, regRdData);
    endtask
    // software side writes zero to reserved bits
    task automatic setRegs(input logic [31:0] i, input logic [31:0] w, input logic [31:0] c);
        idleReg = i & EWIC_IDLE_MASK;
        waitReg = w & EWIC_WAIT_MASK;
        cfgReg = c & EWIC_CFG_MASK;
        regWrite(EWIC_IDLE_OFS, idleReg);
        regWrite(EWIC_WAIT_OFS, waitReg);
        regWrite(EWIC_CFG_OFS, cfgReg);
        regRead(EWIC_WAIT_OFS, waitReg);
    endtask
    task automatic doAcc(input ewic_acc_t a, input bit slow);
        int nI, nS, eW;
        nI = 0;
        nS = 0;
        eW = expWait(a);
        check("ready before take", 1, reqReady);
        @(posedge clk);
        reqValid <= 1'b1;
        reqAcc <= a;
        @(posedge clk);
        reqValid <= 1'b0;
        #1;
        for (int k = 0; k < 300 && accessDone !== 1'b1; k++) begin
            nI += int'(idleActive === 1'b1);
            nS += int'(strobeHold === 1'b1);
            @(posedge clk);
            #1;
        end
        check("access done", 1, accessDone);
        check("idle cycles", expIdle(prevAcc, a), nI);
        if (slow) check("ready stretch", 1, nS > eW + 1);
        else check("access cycles", eW + 1, nS);
        prevAcc = a;
    endtask
    initial begin
        ewic_acc_t a;
        logic [31:0] r, w, cf;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        regRead(EWIC_IDLE_OFS, 32'h7777_7777);
        regRead(EWIC_WAIT_OFS, 32'hFFFE_EFFF);
        regRead(8'h10, 32'h0000_0000);
        regWrite(EWIC_WAIT_OFS, 32'hFFFF_FFFF);
        regRead(EWIC_WAIT_OFS, 32'hFFFE_EFFF);
        a = '0;
        rdyDelay <= 4'h6;
        setRegs(32'h0000_0000, 32'h0000_0008, 32'h0000_0000);
        doAcc(a, 1'b1);
        setRegs(32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
        doAcc(a, 1'b0);
        setRegs(32'h0000_0000, 32'h0000_0008, 32'h0000_0003);
        doAcc(a, 1'b0);
        rdyDelay <= 4'h0;
        for (int c = 0; c < 8; c++) begin
            r = 32'h0000_0000;
            for (int n = 0; n < 7; n++) r[wl[n] +: 3] = 3'(c);
            setRegs({8{1'b0, 3'(c)}}, r, 32'h0000_0000);
            a.area = 3'(c % 7);
            doAcc(a, 1'b0);
            a.area = 3'((c + 1) % 7);
            doAcc(a, 1'b0);
        end
        for (int n = 0; n < 400; n++) begin
            if (n % 16 == 0) begin
                r = nextRand();
                w = nextRand();
                cf = nextRand();
                // ras-down set: software keeps dma_acknowledge_device and area 3 idle at zero
                if (cf[16]) begin
                    r = r & 32'h8FFF_0FFF;
                end
                setRegs(r, w, cf);
            end
            r = nextRand();
            a = ewic_acc_t'(r[6:0]);
            a.area = 3'(r[15:8] % 7);
            @(posedge clk);
            sdramPipeBusy <= r[20];
            dmaSdram <= r[21];
            #1;
            doAcc(a, 1'b0);
        end
        tally_and_finish();
    end
    initial begin
        #600_000;
        num_errors++;
        tally_and_finish();
    end
endmodule
bind ewic_ctrl ewic_ctrl_monitor u_mon (.clk(clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .reqValid(reqValid), .reqReady(reqReady), .idleActive(idleActive),
    .strobeHold(strobeHold), .accessDone(accessDone));
